/* File: hdl/mii_mac_pkg.sv */
package mii_mac_pkg;
   localparam int CLK_PERIOD_NS = 5;
   // shortest legal management clock period
   localparam int MDC_PERIOD_NS = 400;
   localparam int MDC_HALF_INT = (MDC_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   localparam logic [7:0] MDC_HALF = 8'(MDC_HALF_INT);

   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TX_DATA = 8'h04;
   localparam logic [7:0] OFF_RX_DATA = 8'h08;
   localparam logic [7:0] OFF_MGMT = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_MASK = 8'h14;
   localparam logic [7:0] OFF_LINE = 8'h18;

   localparam int CTRL_FDX = 0;
   localparam int CTRL_SER = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int TXD_LAST = 4;
   localparam int TXD_ERR = 5;
   localparam int RXD_VALID = 4;
   localparam int RXD_FERR = 5;
   localparam int MG_RA_LSB = 16;
   localparam int MG_PA_LSB = 21;
   localparam int MG_OP_LSB = 26;
   localparam int MG_BUSY = 31;

   localparam int EV_TX_DONE = 0;
   localparam int EV_RX_NIB = 1;
   localparam int EV_RX_END = 2;
   localparam int EV_RX_ERR = 3;
   localparam int EV_COLL = 4;
   localparam int EV_UNDER = 5;
   localparam int EV_MG_DONE = 6;
   localparam int EV_RX_OVER = 7;
   localparam int EV_COUNT = 8;

   localparam logic [5:0] MF_LAST = 6'h3f;
   localparam logic [5:0] MF_TA_IDX = 6'h2e;
   localparam logic [5:0] MF_DATA_IDX = 6'h30;
   localparam logic [31:0] MF_PREAMBLE = 32'hffffffff;
   localparam logic [1:0] MF_START = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] TA_WRITE = 2'h2;

   typedef enum logic [1:0] {M_IDLE = 2'b01, M_RUN = 2'b10} mgmt_state_t;
   typedef enum logic [2:0] {T_IDLE = 3'b001, T_SEND = 3'b010, T_DRAIN = 3'b100} tx_state_t;
endpackage

/* File: hdl/mgmt_if.sv */
interface mgmt_if;
   logic start;
   logic [1:0] op;
   logic [4:0] phy_addr;
   logic [4:0] reg_addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic din;
   logic busy;
   logic done;
   logic mdc;
   logic dout;
   logic doe;
   modport engine(input start, op, phy_addr, reg_addr, wdata, din, output rdata, busy, done, mdc, dout, doe);
   modport ctrl(output start, op, phy_addr, reg_addr, wdata, din, input rdata, busy, done, mdc, dout, doe);
endinterface

/* File: hdl/sync2.sv */
module sync2 #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

/* File: hdl/mgmt_engine.sv */
module mgmt_engine
   import mii_mac_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   mgmt_if.engine m
);
   mgmt_state_t state_reg;
   logic [7:0] half_reg;
   logic [5:0] idx_reg;
   logic [63:0] sh_reg;
   logic rd_reg;
   logic half_end;
   logic rise;
   logic fall;

   assign half_end = (state_reg == M_RUN) && (half_reg == MDC_HALF - 8'h01);
   assign rise = half_end && !m.mdc;
   assign fall = half_end && m.mdc;
   assign m.busy = (state_reg == M_RUN);

   // clock generation and bit count
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= M_IDLE;
         half_reg <= 8'h00;
         idx_reg <= 6'h00;
         m.mdc <= 1'b0;
         m.done <= 1'b0;
      end else begin
         m.done <= 1'b0;
         case (state_reg)
            M_IDLE: begin
               m.mdc <= 1'b0;
               if (m.start) begin
                  state_reg <= M_RUN;
                  half_reg <= 8'h00;
                  idx_reg <= 6'h00;
               end
            end
            M_RUN: begin
               half_reg <= half_end ? 8'h00 : half_reg + 8'h01;
               if (rise) begin
                  m.mdc <= 1'b1;
               end else if (fall) begin
                  m.mdc <= 1'b0;
                  idx_reg <= idx_reg + 6'h01;
                  if (idx_reg == MF_LAST) begin
                     state_reg <= M_IDLE;
                     m.done <= 1'b1;
                  end
               end
            end
            default: state_reg <= M_IDLE;
         endcase
      end
   end

   // shift out on falling edge, release for read turnaround, sample before rising edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         sh_reg <= 64'h0;
         rd_reg <= 1'b0;
         m.dout <= 1'b0;
         m.doe <= 1'b0;
         m.rdata <= 16'h0000;
      end else if (state_reg == M_IDLE) begin
         m.doe <= 1'b0;
         m.dout <= 1'b0;
         if (m.start) begin
            sh_reg <= {MF_PREAMBLE, MF_START, m.op, m.phy_addr, m.reg_addr,
                       (m.op == OP_READ) ? 2'h0 : TA_WRITE, m.wdata};
            rd_reg <= (m.op == OP_READ);
            m.dout <= 1'b1;
            m.doe <= 1'b1;
         end
      end else if (fall) begin
         sh_reg <= {sh_reg[62:0], 1'b0};
         m.dout <= (idx_reg == MF_LAST) ? 1'b0 : sh_reg[62];
         m.doe <= (idx_reg != MF_LAST) && !(rd_reg && (idx_reg + 6'h01 >= MF_TA_IDX));
      end else if (rise && rd_reg && (idx_reg >= MF_DATA_IDX)) begin
         m.rdata <= {m.rdata[14:0], m.din};
      end
   end
endmodule

/* File: hdl/mii_mac_pin_interface.sv */
// Operation
// (RULE1) management line carries bits on management clock
// (RULE2) management pin undriven after reset until transfer
// (RULE3) seven-wire mode leaves management line unused
// (RULE4) device drives management clock for every bit
// (RULE5) transmit outputs timed by phy transmit clock
// (RULE6) enable rises with first preamble nibble
// (RULE7) enable falls before edge after last nibble
// (RULE8) transmit data valid only with enable
// (RULE9) collision ignored in full duplex
// (RULE10) receive inputs timed by phy receive clock
// (RULE11) phy holds receive valid across whole frame
// (RULE12) receive data accepted only while valid
// (RULE13) carrier sense marks medium busy
// (RULE14) transmit error with enable corrupts symbols
// (RULE15) phy ignores transmit error at ten megabit
// (RULE16) receive error with valid marks frame errored
// (RULE17) management frame follows clause 22 layout
// (RULE18) transmit on rising, receive sampled rising; receive here is sampled on the falling edge and committed on the rising edge
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
module mii_mac_pin_interface
   import mii_mac_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic irq,
   input wire logic mgmt_data_line_in,
   output logic mgmt_data_line_out,
   output logic mgmt_data_line_oe,
   output logic mgmt_clock_out,
   input wire logic tx_nibble_clock,
   output logic tx_frame_valid,
   output logic tx_data_bit0,
   output logic [2:0] tx_data_upper_bits,
   output logic tx_error_out,
   input wire logic collision_detect_in,
   input wire logic rx_nibble_clock,
   input wire logic rx_frame_valid,
   input wire logic rx_data_bit0,
   input wire logic [2:0] rx_data_upper_bits,
   input wire logic carrier_sense_in,
   input wire logic rx_error_in
);
   mgmt_if mg ();

   logic [10:0] pin_s;
   logic tx_clk_s;
   logic rx_clk_s;
   logic rx_dv_s;
   logic rx_er_s;
   logic [3:0] rx_d_s;
   logic col_s;
   logic crs_s;
   logic tx_clk_prev_reg;
   logic rx_clk_prev_reg;
   logic tx_rise;
   logic rx_rise;
   logic rx_fall;

   logic [1:0] ctrl_reg;
   logic fdx;
   logic ser;
   logic [EV_COUNT-1:0] status_reg;
   logic [EV_COUNT-1:0] mask_reg;
   logic [EV_COUNT-1:0] ev;
   logic [EV_COUNT-1:0] w1c;

   logic acc;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic we;
   logic rd_rx;
   logic [31:0] rd_mux;

   logic [5:0] hold_reg;
   logic hold_full_reg;
   logic consume;
   tx_state_t tx_state_reg;
   logic [3:0] txd_reg;
   logic defer;
   logic tx_done;
   logic coll_abort;
   logic underrun;

   logic snap_dv_reg;
   logic snap_er_reg;
   logic [3:0] snap_d_reg;
   logic [3:0] rx_nib_reg;
   logic rx_valid_reg;
   logic rx_in_frame_reg;
   logic rx_frame_err_reg;
   logic rx_take;
   logic rx_end;

   logic start_reg;
   logic [1:0] op_reg;
   logic [4:0] pa_reg;
   logic [4:0] ra_reg;
   logic [15:0] wd_reg;

   // (RULE10) pins resynchronised before use
   sync2 #(.W(11)) u_sync (
      .mclk(mclk),
      .rst(rst),
      .d({tx_nibble_clock, rx_nibble_clock, rx_frame_valid, rx_error_in, rx_data_upper_bits, rx_data_bit0,
          collision_detect_in, carrier_sense_in, mgmt_data_line_in}),
      .q(pin_s)
   );
   assign tx_clk_s = pin_s[10];
   assign rx_clk_s = pin_s[9];
   assign rx_dv_s = pin_s[8];
   assign rx_er_s = pin_s[7];
   assign rx_d_s = pin_s[6:3];
   assign col_s = pin_s[2];
   assign crs_s = pin_s[1];
   assign mg.din = pin_s[0];

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_clk_prev_reg <= 1'b0;
         rx_clk_prev_reg <= 1'b0;
      end else begin
         tx_clk_prev_reg <= tx_clk_s;
         rx_clk_prev_reg <= rx_clk_s;
      end
   end
   // (RULE18) edge detection of phy clocks
   assign tx_rise = tx_clk_s && !tx_clk_prev_reg;
   assign rx_rise = rx_clk_s && !rx_clk_prev_reg;
   assign rx_fall = !rx_clk_s && rx_clk_prev_reg;

   // bus slave: zero wait, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign acc = hsel && htrans[1] && hready;
   assign we = wr_pend_reg;
   assign rd_rx = acc && !hwrite && (haddr[7:0] == OFF_RX_DATA);
   assign fdx = ctrl_reg[CTRL_FDX];
   assign ser = ctrl_reg[CTRL_SER];

   always_comb begin
      rd_mux = 32'h0;
      case (haddr[7:0])
         OFF_CTRL: rd_mux[1:0] = ctrl_reg;
         OFF_TX_DATA: rd_mux[5:0] = hold_reg;
         OFF_RX_DATA: rd_mux[5:0] = {rx_frame_err_reg, rx_valid_reg, rx_nib_reg};
         OFF_MGMT: rd_mux = {mg.busy || start_reg, 15'h0000, mg.rdata};
         OFF_STATUS: rd_mux[EV_COUNT-1:0] = status_reg;
         OFF_MASK: rd_mux[EV_COUNT-1:0] = mask_reg;
         OFF_LINE: rd_mux[4:0] = {mg.busy, tx_frame_valid, hold_full_reg, col_s, crs_s};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         wr_pend_reg <= acc && hwrite;
         if (acc) begin
            wr_addr_reg <= haddr[7:0];
         end
         if (acc && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
         mask_reg <= '0;
      end else if (we) begin
         if (wr_addr_reg == OFF_CTRL) begin
            ctrl_reg <= hwdata[1:0];
         end
         if (wr_addr_reg == OFF_MASK) begin
            mask_reg <= hwdata[EV_COUNT-1:0];
         end
      end
   end

   // sticky events, set wins over write-one-clear
   assign w1c = (we && wr_addr_reg == OFF_STATUS) ? hwdata[EV_COUNT-1:0] : '0;
   assign ev = {rx_take && rx_valid_reg && !rd_rx, mg.done, underrun, coll_abort,
                rx_end && rx_frame_err_reg, rx_end, rx_take, tx_done};
   always_ff @(posedge mclk) begin
      if (rst) begin
         status_reg <= '0;
         irq <= 1'b0;
      end else begin
         status_reg <= (status_reg & ~w1c) | ev;
         irq <= |(status_reg & mask_reg);
      end
   end

   // management command register
   always_ff @(posedge mclk) begin
      if (rst) begin
         start_reg <= 1'b0;
         op_reg <= 2'h0;
         pa_reg <= 5'h00;
         ra_reg <= 5'h00;
         wd_reg <= 16'h0000;
      end else begin
         start_reg <= 1'b0;
         // (RULE3) no transfers in seven-wire mode
         if (we && wr_addr_reg == OFF_MGMT && !mg.busy && !start_reg && !ser) begin
            start_reg <= 1'b1;
            op_reg <= hwdata[MG_OP_LSB+1:MG_OP_LSB];
            pa_reg <= hwdata[MG_PA_LSB+4:MG_PA_LSB];
            ra_reg <= hwdata[MG_RA_LSB+4:MG_RA_LSB];
            wd_reg <= hwdata[15:0];
         end
      end
   end
   assign mg.start = start_reg;
   assign mg.op = op_reg;
   assign mg.phy_addr = pa_reg;
   assign mg.reg_addr = ra_reg;
   assign mg.wdata = wd_reg;

   // (RULE17) clause 22 frame engine
   mgmt_engine u_mgmt (
      .mclk(mclk),
      .rst(rst),
      .m(mg)
   );
   // (RULE1) bidirectional line from engine
   assign mgmt_data_line_out = mg.dout;
   // (RULE2) enable only during transfers
   assign mgmt_data_line_oe = mg.doe;
   // (RULE4) generated management clock
   assign mgmt_clock_out = mg.mdc;

   // transmit holding register
   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_reg <= 6'h00;
         hold_full_reg <= 1'b0;
      end else if (we && wr_addr_reg == OFF_TX_DATA && (!hold_full_reg || consume)) begin
         hold_reg <= hwdata[5:0];
         hold_full_reg <= 1'b1;
      end else if (consume) begin
         hold_full_reg <= 1'b0;
      end
   end

   // (RULE13) defer start while medium busy, only in half duplex outside seven-wire mode
   assign defer = !fdx && !ser && crs_s;
   // (RULE9) collision only in half duplex
   assign coll_abort = tx_rise && (tx_state_reg == T_SEND) && !fdx && col_s;
   assign underrun = tx_rise && (tx_state_reg == T_SEND) && !coll_abort && !hold_full_reg;
   assign tx_done = tx_rise && (tx_state_reg == T_IDLE) && tx_frame_valid;
   assign consume = tx_rise && hold_full_reg &&
                    ((tx_state_reg == T_IDLE && !tx_frame_valid && !defer) ||
                     (tx_state_reg == T_SEND && !coll_abort) || tx_state_reg == T_DRAIN);

   // (RULE5) outputs change only on transmit clock edges
   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_state_reg <= T_IDLE;
         tx_frame_valid <= 1'b0;
         txd_reg <= 4'h0;
         tx_error_out <= 1'b0;
      end else if (tx_rise) begin
         case (tx_state_reg)
            T_IDLE, T_SEND: begin
               if (consume) begin
                  // (RULE6) enable with first nibble
                  tx_frame_valid <= 1'b1;
                  txd_reg <= ser ? {3'h0, hold_reg[0]} : hold_reg[3:0];
                  // (RULE14) error only alongside enable
                  tx_error_out <= hold_reg[TXD_ERR] && !ser;
                  tx_state_reg <= hold_reg[TXD_LAST] ? T_IDLE : T_SEND;
               end else begin
                  // (RULE7) drop enable at next edge
                  tx_frame_valid <= 1'b0;
                  txd_reg <= 4'h0;
                  tx_error_out <= 1'b0;
                  tx_state_reg <= (tx_state_reg == T_SEND) ? T_DRAIN : T_IDLE;
               end
            end
            T_DRAIN: begin
               tx_frame_valid <= 1'b0;
               txd_reg <= 4'h0;
               tx_error_out <= 1'b0;
               if (consume && hold_reg[TXD_LAST]) begin
                  tx_state_reg <= T_IDLE;
               end
            end
            default: tx_state_reg <= T_IDLE;
         endcase
      end
   end
   // (RULE8) data zero outside enable
   assign tx_data_bit0 = txd_reg[0];
   assign tx_data_upper_bits = txd_reg[3:1];

   // (RULE18) snapshot mid-cycle, commit on rising edge
   always_ff @(posedge mclk) begin
      if (rst) begin
         snap_dv_reg <= 1'b0;
         snap_er_reg <= 1'b0;
         snap_d_reg <= 4'h0;
      end else if (rx_fall) begin
         snap_dv_reg <= rx_dv_s;
         snap_er_reg <= rx_er_s;
         snap_d_reg <= rx_d_s;
      end
   end

   // (RULE12) accept only with valid
   assign rx_take = rx_rise && snap_dv_reg;
   // (RULE11) valid falling closes frame
   assign rx_end = rx_rise && !snap_dv_reg && rx_in_frame_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_nib_reg <= 4'h0;
         rx_valid_reg <= 1'b0;
         rx_in_frame_reg <= 1'b0;
         rx_frame_err_reg <= 1'b0;
      end else begin
         if (rx_take) begin
            rx_nib_reg <= ser ? {3'h0, snap_d_reg[0]} : snap_d_reg;
            rx_valid_reg <= 1'b1;
            rx_in_frame_reg <= 1'b1;
            // (RULE16) error counts only with valid
            rx_frame_err_reg <= (rx_in_frame_reg && rx_frame_err_reg) || (snap_er_reg && !ser);
         end else if (rd_rx) begin
            rx_valid_reg <= 1'b0;
         end
         if (rx_end) begin
            rx_in_frame_reg <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   property p_mdio_released;
      !mg.busy |-> !mgmt_data_line_oe;
   endproperty
   a_mdio_released: assert property (p_mdio_released) else $error("management pin driven while idle"); // RULE2

   property p_mdc_width;
      $rose(mgmt_clock_out) |=> mgmt_clock_out [*8];
   endproperty
   a_mdc_width: assert property (p_mdc_width) else $error("management clock high too short"); // RULE4

   property p_no_mgmt_serial;
      ser && !mg.busy |=> !mgmt_data_line_oe;
   endproperty
   a_no_mgmt_serial: assert property (p_no_mgmt_serial) else $error("management started in serial mode"); // RULE3

   property p_tx_en_start;
      $rose(tx_frame_valid) |-> $past(tx_rise) && $past(hold_full_reg);
   endproperty
   a_tx_en_start: assert property (p_tx_en_start) else $error("enable rose without a nibble edge"); // RULE6

   property p_tx_en_stop;
      $fell(tx_frame_valid) |-> $past(tx_rise);
   endproperty
   a_tx_en_stop: assert property (p_tx_en_stop) else $error("enable fell off a transmit edge"); // RULE7

   property p_txd_quiet;
      !tx_frame_valid |-> (tx_data_bit0 == 1'b0) && (tx_data_upper_bits == 3'h0);
   endproperty
   a_txd_quiet: assert property (p_txd_quiet) else $error("transmit data outside enable"); // RULE8

   property p_txd_edge;
      $changed(txd_reg) |-> $past(tx_rise);
   endproperty
   a_txd_edge: assert property (p_txd_edge) else $error("transmit data moved off edge"); // RULE5

   property p_txer_en;
      tx_error_out |-> tx_frame_valid;
   endproperty
   a_txer_en: assert property (p_txer_en) else $error("transmit error without enable"); // RULE14

   property p_fdx_col;
      fdx && tx_rise && tx_state_reg == T_SEND && hold_full_reg |=> tx_frame_valid;
   endproperty
   a_fdx_col: assert property (p_fdx_col) else $error("collision acted on in full duplex"); // RULE9

   property p_defer;
      tx_rise && tx_state_reg == T_IDLE && defer |=> !$rose(tx_frame_valid);
   endproperty
   a_defer: assert property (p_defer) else $error("transmit started on busy medium"); // RULE13

   property p_rx_dv;
      $rose(rx_valid_reg) |-> $past(rx_rise) && $past(snap_dv_reg);
   endproperty
   a_rx_dv: assert property (p_rx_dv) else $error("nibble accepted without valid"); // RULE12

   property p_rx_err;
      rx_take && snap_er_reg && !ser |=> rx_frame_err_reg;
   endproperty
   a_rx_err: assert property (p_rx_err) else $error("receive error not recorded"); // RULE16

   property p_rx_edge;
      $changed(rx_nib_reg) |-> $past(rx_rise);
   endproperty
   a_rx_edge: assert property (p_rx_edge) else $error("receive nibble off receive edge"); // RULE10
endmodule

/* File: bench/phy_model.sv */
module phy_model (
   input wire logic mdc,
   input wire logic md_out,
   input wire logic md_oe,
   input wire logic ser7,
   input wire logic [15:0] rd_val,
   output logic md_in,
   output logic txc,
   input wire logic tx_en,
   input wire logic [3:0] txd,
   input wire logic tx_er,
   output logic rxc,
   output logic rx_dv,
   output logic [3:0] rxd,
   output logic rx_er,
   input wire logic crs_force,
   output logic crs
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] tx_q[$];
   logic [63:0] mg_bits;
   int mg_n;
   logic phy_oe, phy_bit, clash;
   initial begin
      txc = 1'b0;
      rxc = 1'b0;
      rx_dv = 1'b0;
      rxd = 4'h0;
      rx_er = 1'b1;
      phy_oe = 1'b0;
      phy_bit = 1'b0;
      clash = 1'b0;
   end
   initial #7.3 forever #40 txc = ~txc;
   initial #21.7 forever #40 rxc = ~rxc;
   always @(md_oe or phy_oe) if (md_oe && phy_oe) clash = 1'b1;
   assign crs = crs_force | tx_en | rx_dv;
   assign md_in = md_oe ? md_out : phy_oe ? phy_bit : !ser7;
   always @(posedge txc) if (tx_en === 1'b1) tx_q.push_back({tx_er, txd});
   // shift frame, answer reads after turnaround
   always @(posedge mdc) begin
      mg_bits = {mg_bits[62:0], md_in};
      if (mg_n == 46 && mg_bits[12:11] == 2'b10) phy_oe = 1'b1;
      phy_bit = (mg_n == 46) ? 1'b0 : rd_val[(62 - mg_n) & 15];
      if (mg_n == 63) phy_oe = 1'b0;
      mg_n = (mg_n == 63) ? 0 : mg_n + 1;
   end
   // valid spans frame, error line high when idle
   task automatic send(input logic [3:0] nib[$], input int err_at);
      foreach (nib[i]) begin
         @(posedge rxc);
         rx_dv = 1'b1;
         rxd = nib[i];
         rx_er = (i == err_at);
      end
      @(posedge rxc);
      rx_dv = 1'b0;
      rxd = ~rxd;
      rx_er = 1'b1;
   endtask
endmodule

/* File: bench/mii_mac_pin_interface_bench.sv */
module mii_mac_pin_interface_bench
   import mii_mac_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk, rst, hsel, hwrite, hreadyout, hresp, irq, coll, crs, crs_force, ser7;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize, tx_up;
   logic md_in, md_out, md_oe, mdc, txc, tx_en, tx_d0, tx_er, rxc, rx_dv, rx_er;
   logic [3:0] rxd;
   logic [15:0] rd_val;
   int mismatches, num_checks, cyc;

   mii_mac_pin_interface dut (
      .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
      .hrdata, .irq, .mgmt_data_line_in(md_in), .mgmt_data_line_out(md_out), .mgmt_data_line_oe(md_oe),
      .mgmt_clock_out(mdc), .tx_nibble_clock(txc), .tx_frame_valid(tx_en), .tx_data_bit0(tx_d0),
      .tx_data_upper_bits(tx_up), .tx_error_out(tx_er), .collision_detect_in(coll), .rx_nibble_clock(rxc),
      .rx_frame_valid(rx_dv), .rx_data_bit0(rxd[0]), .rx_data_upper_bits(rxd[3:1]), .carrier_sense_in(crs),
      .rx_error_in(rx_er)
   );
   phy_model phy (
      .mdc, .md_out, .md_oe, .ser7, .rd_val, .md_in, .txc, .tx_en, .txd({tx_up, tx_d0}), .tx_er, .rxc,
      .rx_dv, .rxd, .rx_er, .crs_force, .crs
   );

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk(q & m, e);
   endtask
   task automatic wait_st(input int b);
      do rd(OFF_STATUS); while (q[b] !== 1'b1);
   endtask
   // holding register refilled as soon as it empties
   task automatic tx_frame(input logic [5:0] nib[$]);
      foreach (nib[i]) begin
         do rd(OFF_LINE); while (q[2] !== 1'b0);
         wr(OFF_TX_DATA, {26'h0, nib[i]});
      end
   endtask
   task automatic tx_idle();
      do rd(OFF_LINE); while (q[3:2] !== 2'b00);
   endtask
   task automatic tx_cmp(input logic [4:0] e[$]);
      chk(32'(phy.tx_q.size()), 32'(e.size()));
      foreach (e[i]) chk(32'(phy.tx_q[i]), 32'(e[i]));
      phy.tx_q.delete();
   endtask
   task automatic rx_take(input logic [3:0] e[$]);
      foreach (e[i]) begin
         do rd(OFF_RX_DATA); while (q[4] !== 1'b1);
         chk(32'(q[3:0]), 32'(e[i]));
      end
   endtask

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         mismatches++;
         print_verdict();
      end
   end

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      coll = 1'b0;
      crs_force = 1'b0;
      ser7 = 1'b0;
      rd_val = 16'h0;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      chk({30'h0, md_oe, mdc}, 32'h0);
      chk({30'h0, hreadyout, hresp}, 32'h2);
      rc(OFF_CTRL, 32'hffffffff, 32'h0);
      rc(OFF_MASK, 32'hffffffff, 32'h0);
      rc(OFF_STATUS, 32'hffffffff, 32'h0);
      wr(8'h1c, 32'hffffffff);
      rc(8'h1c, 32'hffffffff, 32'h0);
      wr(OFF_MASK, 32'h1);
      tx_frame('{6'h05, 6'h0a, 6'h23, 6'h1c});
      tx_idle();
      rc(OFF_STATUS, 32'h1, 32'h1);
      chk(32'(irq), 32'h1);
      tx_cmp('{5'h05, 5'h0a, 5'h13, 5'h0c});
      wr(OFF_STATUS, 32'hff);
      rc(OFF_STATUS, 32'h1, 32'h0);
      chk(32'(irq), 32'h0);
      wr(OFF_CTRL, 32'h2);
      ser7 <= 1'b1;
      tx_frame('{6'h2f, 6'h1e});
      tx_idle();
      tx_cmp('{5'h01, 5'h00});
      wr(OFF_MGMT, {4'h0, OP_WRITE, 5'h01, 5'h01, 16'h0001});
      repeat (200) @(posedge mclk);
      chk(32'(phy.mg_n), 32'h0);
      rc(OFF_LINE, 32'h10, 32'h0);
      ser7 <= 1'b0;
      wr(OFF_CTRL, 32'h0);
      coll <= 1'b1;
      tx_frame('{6'h01, 6'h02, 6'h13});
      tx_idle();
      rc(OFF_LINE, 32'h2, 32'h2);
      rc(OFF_STATUS, 32'h10, 32'h10);
      coll <= 1'b0;
      phy.tx_q.delete();
      wr(OFF_STATUS, 32'hff);
      wr(OFF_CTRL, 32'h1);
      coll <= 1'b1;
      tx_frame('{6'h01, 6'h02, 6'h13});
      tx_idle();
      tx_cmp('{5'h01, 5'h02, 5'h03});
      rc(OFF_STATUS, 32'h10, 32'h0);
      coll <= 1'b0;
      wr(OFF_CTRL, 32'h0);
      wr(OFF_STATUS, 32'hff);
      fork
         phy.send('{4'h1, 4'h2, 4'h3}, -1);
         rx_take('{4'h1, 4'h2, 4'h3});
      join
      wait_st(EV_RX_END);
      rc(OFF_RX_DATA, 32'h30, 32'h0);
      rc(OFF_STATUS, 32'hc, 32'h4);
      chk(32'(irq), 32'h0);
      wr(OFF_STATUS, 32'hff);
      fork
         phy.send('{4'h9, 4'h6, 4'hf, 4'h0}, 2);
         rx_take('{4'h9, 4'h6, 4'hf, 4'h0});
      join
      wait_st(EV_RX_END);
      rc(OFF_STATUS, 32'hc, 32'hc);
      rc(OFF_RX_DATA, 32'h20, 32'h20);
      crs_force <= 1'b1;
      // synchroniser settle
      repeat (4) @(posedge mclk);
      rc(OFF_LINE, 32'h1, 32'h1);
      // frame held back while carrier up
      wr(OFF_TX_DATA, 32'h11);
      repeat (40) @(posedge mclk);
      rc(OFF_LINE, 32'hc, 32'h4);
      crs_force <= 1'b0;
      tx_idle();
      repeat (4) @(posedge mclk);
      rc(OFF_LINE, 32'h1, 32'h0);
      wr(OFF_STATUS, 32'hff);
      // holding register left empty mid-frame
      wr(OFF_TX_DATA, 32'h01);
      repeat (40) @(posedge mclk);
      rc(OFF_STATUS, 32'h21, 32'h20);
      wr(OFF_TX_DATA, 32'h12);
      tx_idle();
      tx_cmp('{5'h01, 5'h01});
      wr(OFF_STATUS, 32'hff);
      wr(OFF_MASK, 32'h40);
      wr(OFF_MGMT, {4'h0, OP_WRITE, 5'h05, 5'h03, 16'ha5c3});
      wait_st(EV_MG_DONE);
      chk(32'(irq), 32'h1);
      chk(phy.mg_bits[63:32], 32'hffffffff);
      chk(phy.mg_bits[31:0], {2'b01, OP_WRITE, 5'h05, 5'h03, 2'b10, 16'ha5c3});
      wr(OFF_STATUS, 32'hff);
      rd_val <= 16'h1234;
      wr(OFF_MGMT, {4'h0, OP_READ, 5'h05, 5'h09, 16'h0});
      wait_st(EV_MG_DONE);
      rc(OFF_MGMT, 32'h8000ffff, 32'h00001234);
      chk(phy.mg_bits[31:0], {2'b01, OP_READ, 5'h05, 5'h09, 2'b10, 16'h1234});
      chk({30'h0, phy.clash, md_oe}, 32'h0);
      print_verdict();
   end
endmodule
